// File: core/osc_ctrl_pkg.sv
// Package for the oscillator and loop clock control block.
// Assumes an APB master on pclk with 32-bit data.
package osc_ctrl_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_EXT_OSC  = 8'h00;
  localparam logic [7:0] ADDR_FLL      = 8'h04;
  localparam logic [7:0] ADDR_PLL_RAT  = 8'h08;
  localparam logic [7:0] ADDR_PLL_CTL  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  // ext_osc_control fields
  localparam int XO_ENABLE   = 1;
  localparam int XO_CRYSTAL  = 2;
  localparam int XO_STANDBY  = 6;
  localparam int XO_ONREQ    = 7;
  // fll_control fields
  localparam int FL_ENABLE   = 1;
  localparam int FL_MODE     = 2;
  localparam int FL_STABLE   = 3;
  localparam int FL_DROPLOCK = 4;
  localparam int FL_STANDBY  = 6;
  localparam int FL_ONREQ    = 7;
  // pll_ratio fields: int in [11:0], frac in [19:16]
  localparam int PR_INT_LSB  = 0;
  localparam int PR_FRAC_LSB = 16;
  // pll control fields
  localparam int PC_ENABLE   = 1;
  localparam int PC_REFSEL   = 4;
  localparam int PC_DIV_LSB  = 16;
  // Reset values
  localparam logic [15:0] EXT_OSC_RESET = 16'h0080;
  localparam logic [15:0] FLL_RESET     = 16'h0080;
  localparam logic [31:0] PLL_RAT_RESET = 32'h0000_0000;
  localparam logic [31:0] PLL_CTL_RESET = 32'h0000_0000;
  // Cycles per leg of the sync handshake; each leg crosses two flops
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    REF_32K = 2'h0, REF_XOSC = 2'h1, REF_GEN = 2'h2
  } ref_sel_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001, S_REQ = 3'b010, S_ACK = 3'b100
  } sync_state_t;

  typedef struct packed {
    logic        enable;
    logic        loop_closed;
    logic        freeze_fine;
    logic        drop_lock;
  } fll_ctl_t;

  typedef struct packed {
    logic        run;
    logic        pll_run;
    ref_sel_t    ref_sel;
    logic [10:0] ref_div;
    logic [11:0] loop_ratio_int;
    logic [3:0]  loop_ratio_frac;
    logic        frac_mode;
  } pll_cfg_t;
endpackage : osc_ctrl_pkg

// File: core/osc_ctrl.sv
// Oscillator, frequency-locked loop and PLL control with write sync.
// Assumes APB on pclk, which also clocks the peripheral-domain copies, and sleep
// and request levels that arrive asynchronously from the system.
//
// Operation
// R1: One common synchronizer serves all registers; one transfer at a time; here the oscillator control register is written without it.
// R2: A bus write to a peripheral-domain register starts a sync transfer.
// R3: Sync busy flag sets when the transfer starts, clears when done.
// R4: Accesses during busy stall the bus until the transfer completes; here status reads do not stall.
// R5: PLL output equals ref times (int ratio + 1 + frac/16).
// R6: With oscillator reference, ref equals osc over 2*(div+1).
// R7: PLL reference is 32k oscillator, oscillator, or generic clock.
// R8: Disabling the PLL resets its output; zero frac means integer mode.
// R9: Software enables the 32 kHz lock timer clock before PLL use.
// R10: Oscillator standby 0 stops it in standby; 1 runs, per on-request.
// R11: Crystal select 0 takes clock on input pin, frees output pin.
// R12: Without on-request, an enabled oscillator runs continuously.
// R13: With on-request, oscillator runs only while some peripheral requests.
// R14: Loop in standby keeps on-request only if its standby-run bit is set.
// R15: Drop-lock bit 1 drops loop lock after sleep with stopped clock.
// R16: Stable bit 1 freezes fine calibration after fine lock.
// R17: Mode bit 0 selects open loop, 1 closed loop.
// R18: Loop enable reads back at once; takes effect after sync delay.
// R19: Pready held low while stalled, released cycle after busy clears.
module osc_ctrl
(
  // APB
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // System levels, asynchronous
  input  wire logic                     standby,
  input  wire logic                     osc_request,
  input  wire logic                     fll_request,
  input  wire logic                     fll_clk_stopped,
  input  wire logic                     fll_fine_lock,
  input  wire logic                     pll_lock,
  // Controls to the analog and clock cells
  output logic                          ext_osc_run,
  output logic                          crystal_select,
  output logic                          osc_out_pin_gpio,
  output logic                          fll_run,
  output osc_ctrl_pkg::fll_ctl_t        fll_ctl,
  output logic                          fll_lock,
  output osc_ctrl_pkg::pll_cfg_t        pll_cfg,
  output logic                          sync_in_progress
);
  import osc_ctrl_pkg::*;

  logic [15:0]  ext_osc_control;
  logic [15:0]  fll_control;
  logic [31:0]  pll_ratio;
  logic [31:0]  pll_control;
  // Peripheral-domain copies, updated only after sync
  logic [15:0]  fll_active;
  logic [31:0]  pll_ratio_active;
  logic [31:0]  pll_control_active;
  sync_state_t  state;
  logic [1:0]   sync_cnt;
  logic [1:0]   tgt;
  logic [31:0]  hold_data;
  logic [5:0]   meta;
  logic [5:0]   lvl;

  wire access    = psel && penable;
  wire is_synced = (paddr == ADDR_FLL) || (paddr == ADDR_PLL_RAT) || (paddr == ADDR_PLL_CTL);
  wire mapped    = is_synced || (paddr == ADDR_EXT_OSC) || (paddr == ADDR_STATUS);
  wire busy      = state != S_IDLE;
  // Stalled access waits; the status register itself stays readable
  wire stall     = busy && !(paddr == ADDR_STATUS && !pwrite); // see R4
  wire wr_fire   = access && pwrite && !stall && !pready;

  // Two-flop synchronisers for the asynchronous levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 6'h00;
      lvl  <= 6'h00;
    end else if (clk_en) begin
      meta <= {standby, osc_request, fll_request, fll_clk_stopped, fll_fine_lock, pll_lock};
      lvl  <= meta;
    end
  end
  wire s_stby = lvl[5];
  wire s_oreq = lvl[4];
  wire s_freq = lvl[3];
  wire s_stop = lvl[2];
  wire s_fine = lvl[1];
  wire s_plck = lvl[0];

  // APB handshake: one wait state at least, longer while stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (access && !pready && !stall) begin // see R19
        pready  <= 1'b1;
        pslverr <= !mapped;
        prdata  <= 32'h0000_0000;
        if (!pwrite) begin
          if (paddr == ADDR_EXT_OSC) begin
            prdata <= {16'h0000, ext_osc_control};
          end else if (paddr == ADDR_FLL) begin
            prdata <= {16'h0000, fll_control}; // see R18
          end else if (paddr == ADDR_PLL_RAT) begin
            prdata <= pll_ratio;
          end else if (paddr == ADDR_PLL_CTL) begin
            prdata <= pll_control;
          end else if (paddr == ADDR_STATUS) begin
            prdata <= {28'h0000000, fll_lock, s_plck, s_fine, sync_in_progress};
          end
        end
      end
    end
  end

  // Bus-domain register copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_osc_control <= EXT_OSC_RESET;
      fll_control     <= FLL_RESET;
      pll_ratio       <= PLL_RAT_RESET;
      pll_control     <= PLL_CTL_RESET;
    end else if (clk_en && wr_fire) begin
      if (paddr == ADDR_EXT_OSC) begin
        ext_osc_control <= pwdata[15:0];
      end else if (paddr == ADDR_FLL) begin
        fll_control <= pwdata[15:0];
      end else if (paddr == ADDR_PLL_RAT) begin
        pll_ratio <= pwdata;
      end else if (paddr == ADDR_PLL_CTL) begin
        pll_control <= pwdata;
      end
    end
  end

  // Common synchronizer: one transfer for whichever synced register was written.
  // Sharing one path saves area at the cost of stalling back-to-back writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= S_IDLE;
      sync_cnt  <= 2'h0;
      tgt       <= 2'h0;
      hold_data <= 32'h0000_0000;
    end else if (clk_en) begin
      case (state)
        S_IDLE: begin
          if (wr_fire && is_synced) begin // see R1, R2
            state     <= S_REQ;
            sync_cnt  <= 2'h0;
            tgt       <= paddr[3:2];
            hold_data <= pwdata;
          end
        end
        S_REQ: begin
          sync_cnt <= sync_cnt + 2'h1;
          if (sync_cnt == 2'(SYNC_STAGES - 1)) begin
            state    <= S_ACK;
            sync_cnt <= 2'h0;
          end
        end
        S_ACK: begin
          sync_cnt <= sync_cnt + 2'h1;
          if (sync_cnt == 2'(SYNC_STAGES - 1)) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_in_progress <= 1'b0;
    end else if (clk_en) begin
      if (state == S_IDLE && wr_fire && is_synced) begin
        sync_in_progress <= 1'b1; // see R3
      end else if (state == S_ACK && sync_cnt == 2'(SYNC_STAGES - 1)) begin
        sync_in_progress <= 1'b0; // see R3
      end
    end
  end

  // Values take effect only at the end of the request leg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fll_active         <= FLL_RESET;
      pll_ratio_active   <= PLL_RAT_RESET;
      pll_control_active <= PLL_CTL_RESET;
    end else if (clk_en && state == S_REQ && sync_cnt == 2'(SYNC_STAGES - 1)) begin
      if (tgt == ADDR_FLL[3:2]) begin
        fll_active <= hold_data[15:0]; // see R18
      end else if (tgt == ADDR_PLL_RAT[3:2]) begin
        pll_ratio_active <= hold_data;
      end else begin
        pll_control_active <= hold_data;
      end
    end
  end

  // External oscillator run decision
  wire xo_en  = ext_osc_control[XO_ENABLE];
  wire xo_on  = ext_osc_control[XO_ONREQ] ? s_oreq : 1'b1; // see R12, R13
  wire xo_sb  = ext_osc_control[XO_STANDBY];              // see R10
  wire next_ext_osc_run = xo_en && (s_stby ? (xo_sb && xo_on) : xo_on);

  // Loop run decision
  wire fl_en  = fll_active[FL_ENABLE];
  wire fl_on  = fll_active[FL_ONREQ] ? s_freq : 1'b1;
  wire next_fll_run = fl_en && (s_stby ? (fll_active[FL_STANDBY] && fl_on) : fl_on); // see R14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_osc_run      <= 1'b0;
      crystal_select   <= 1'b0;
      osc_out_pin_gpio <= 1'b1;
      fll_run          <= 1'b0;
      fll_ctl          <= '0;
    end else if (clk_en) begin
      ext_osc_run      <= next_ext_osc_run;
      crystal_select   <= ext_osc_control[XO_CRYSTAL];   // see R11
      osc_out_pin_gpio <= !ext_osc_control[XO_CRYSTAL];  // see R11
      fll_run          <= next_fll_run;
      fll_ctl.enable      <= fl_en;
      fll_ctl.loop_closed <= fll_active[FL_MODE];        // see R17
      fll_ctl.freeze_fine <= fll_active[FL_STABLE] && s_fine; // see R16
      fll_ctl.drop_lock   <= fll_active[FL_DROPLOCK];
    end
  end

  // Lock status: dropped on wake when clock stopped and drop-lock set
  logic was_stby;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      was_stby <= 1'b0;
      fll_lock <= 1'b0;
    end else if (clk_en) begin
      was_stby <= s_stby;
      if (!fl_en) begin
        fll_lock <= 1'b0;
      end else if (was_stby && !s_stby && s_stop && fll_active[FL_DROPLOCK]) begin
        fll_lock <= 1'b0; // see R15
      end else if (s_fine) begin
        fll_lock <= 1'b1;
      end
    end
  end

  // PLL configuration to the analog core; frequency relations hold there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_cfg <= '0;
    end else if (clk_en) begin
      pll_cfg.run     <= pll_control_active[PC_ENABLE];
      // Output gate forced off while disabled, so the clock is reset
      pll_cfg.pll_run <= pll_control_active[PC_ENABLE] && s_plck; // see R8
      pll_cfg.ref_sel <= ref_sel_t'(pll_control_active[PC_REFSEL +: 2]); // see R7, R9
      pll_cfg.ref_div <= pll_control_active[PC_DIV_LSB +: 11]; // see R6
      pll_cfg.loop_ratio_int  <= pll_ratio_active[PR_INT_LSB +: 12]; // see R5
      pll_cfg.loop_ratio_frac <= pll_ratio_active[PR_FRAC_LSB +: 4]; // see R5
      pll_cfg.frac_mode <= pll_ratio_active[PR_FRAC_LSB +: 4] != 4'h0; // see R8
    end
  end

  // Assertions
  a_busy_sets: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    clk_en && state == S_IDLE && wr_fire && is_synced |=> sync_in_progress)
    else $error("sync busy not set on synced write");

  a_busy_len: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    $rose(sync_in_progress) && clk_en |-> sync_in_progress [*4])
    else $error("sync busy too short");

  a_stall_ready: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    pready |-> !$past(stall))
    else $error("ready given during stall");

  a_ready_after: assert property (@(posedge pclk) disable iff (!presetn) // see R19
    (access && !pready && busy) ##1 (access && !pready && !busy && clk_en)
    |=> pready)
    else $error("ready not released after sync");

  a_fll_readback: assert property (@(posedge pclk) disable iff (!presetn) // see R18
    clk_en && wr_fire && paddr == ADDR_FLL |=> fll_control == $past(pwdata[15:0]))
    else $error("loop enable not read back at once");

  a_fll_delay: assert property (@(posedge pclk) disable iff (!presetn) // see R18
    clk_en && wr_fire && paddr == ADDR_FLL && !busy |=> fll_active == $past(fll_active))
    else $error("loop control took effect without delay");

  a_xo_standby: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    clk_en && s_stby && !xo_sb |=> !ext_osc_run)
    else $error("oscillator ran in standby");

  a_xo_always: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    clk_en && xo_en && !ext_osc_control[XO_ONREQ] && !s_stby |=> ext_osc_run)
    else $error("oscillator not running continuously");

  a_pll_off: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    clk_en && !pll_control_active[PC_ENABLE] |=> !pll_cfg.pll_run)
    else $error("pll output not reset when disabled");

  a_single_sync: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    busy && clk_en |=> $stable(hold_data))
    else $error("second sync started while busy");

  a_loop_mode: assert property (@(posedge pclk) disable iff (!presetn) // see R17
    clk_en |=> fll_ctl.loop_closed == $past(fll_active[FL_MODE]))
    else $error("loop mode mismatch");

  a_sync_start: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    clk_en && wr_fire && is_synced && !busy |=> busy && tgt == $past(paddr[3:2]))
    else $error("synced write did not start a transfer");

  a_ratio_pass: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    clk_en |=> pll_cfg.loop_ratio_int == $past(pll_ratio_active[PR_INT_LSB +: 12])
    && pll_cfg.loop_ratio_frac == $past(pll_ratio_active[PR_FRAC_LSB +: 4]))
    else $error("loop ratio not passed to the pll");

  a_ref_div: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    clk_en |=> pll_cfg.ref_div == $past(pll_control_active[PC_DIV_LSB +: 11]))
    else $error("reference divider mismatch");

  a_ref_select: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    clk_en |=> pll_cfg.ref_sel == $past(pll_control_active[PC_REFSEL +: 2]))
    else $error("reference select mismatch");

  a_frac_mode: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    clk_en |=> pll_cfg.frac_mode == ($past(pll_ratio_active[PR_FRAC_LSB +: 4]) != 4'h0))
    else $error("fractional mode mismatch");

  a_crystal_pins: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    clk_en |=> crystal_select == $past(ext_osc_control[XO_CRYSTAL]) && osc_out_pin_gpio != crystal_select)
    else $error("crystal pin use mismatch");

  a_xo_on_request: assert property (@(posedge pclk) disable iff (!presetn) // see R13
    clk_en && ext_osc_control[XO_ONREQ] && !s_oreq |=> !ext_osc_run)
    else $error("oscillator ran without a request");

  a_fll_standby: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    clk_en && s_stby && !fll_active[FL_STANDBY] |=> !fll_run)
    else $error("loop ran in standby");

  a_lock_drop: assert property (@(posedge pclk) disable iff (!presetn) // see R15
    clk_en && was_stby && !s_stby && s_stop && fll_active[FL_DROPLOCK] |=> !fll_lock)
    else $error("lock kept after wake");

  a_fine_freeze: assert property (@(posedge pclk) disable iff (!presetn) // see R16
    clk_en && !fll_active[FL_STABLE] |=> !fll_ctl.freeze_fine)
    else $error("fine calibration frozen while tracking");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // see R19
    pready && clk_en |=> !pready)
    else $error("ready held longer than one cycle");

  c_sync_write: cover property (@(posedge pclk) $rose(sync_in_progress));
  c_lock_drop: cover property (@(posedge pclk) fll_lock ##1 !fll_lock);
  c_stall: cover property (@(posedge pclk) access && stall ##1 access && !stall);
  c_standby: cover property (@(posedge pclk) s_stby && ext_osc_run);
  c_frac: cover property (@(posedge pclk) pll_cfg.frac_mode && pll_cfg.pll_run);
endmodule : osc_ctrl

// File: dv/tb_oscillator_pll_control.sv
// Self-checking bench for the oscillator and loop clock control block.
// Assumes osc_ctrl with an APB slave on pclk; the bench is the only master.
module tb_oscillator_pll_control;
  timeunit 1ns;
  timeprecision 1ns;
  import osc_ctrl_pkg::*;

  // Bus and levels
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic        standby, osc_request, fll_request, fll_clk_stopped, fll_fine_lock, pll_lock;
  // Observed controls
  logic        ext_osc_run, crystal_select, osc_out_pin_gpio, fll_run, fll_lock;
  logic        sync_in_progress;
  fll_ctl_t    fll_ctl;
  pll_cfg_t    pll_cfg;
  int          error_cnt, check_count, wait_cnt;
  logic        busy_at_ans;
  logic [31:0] rdv;

  osc_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
    .osc_request(osc_request), .fll_request(fll_request),
    .fll_clk_stopped(fll_clk_stopped), .fll_fine_lock(fll_fine_lock),
    .pll_lock(pll_lock), .ext_osc_run(ext_osc_run), .crystal_select(crystal_select),
    .osc_out_pin_gpio(osc_out_pin_gpio), .fll_run(fll_run), .fll_ctl(fll_ctl),
    .fll_lock(fll_lock), .pll_cfg(pll_cfg), .sync_in_progress(sync_in_progress));

  always #50 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Entered just after a rising edge; holds the request until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    busy_at_ans = sync_in_progress;
    wait_cnt = n;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic e;
    apb(1'b0, a, 32'h0, rdv, e);
    chk(rdv, exp);
    chk({31'h0, e}, 32'h0);
  endtask : rd

  // Level inputs cross two flops, then a register: five edges is ample
  task automatic settle;
    repeat (5) @(posedge pclk);
  endtask : settle

  task automatic wait_sync;
    int n;
    n = 0;
    while (sync_in_progress !== 1'b0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    chk({31'h0, sync_in_progress}, 32'h0);
  endtask : wait_sync

  task automatic t_reset;
    rd(ADDR_EXT_OSC, 32'h0000_0080);
    rd(ADDR_FLL, 32'h0000_0080);
    rd(ADDR_PLL_RAT, 32'h0);
    rd(ADDR_PLL_CTL, 32'h0);
    chk({29'h0, osc_out_pin_gpio, crystal_select, ext_osc_run}, 32'h4);
  endtask : t_reset

  task automatic t_unmapped;
    logic e;
    apb(1'b0, 8'h14, 32'h0, rdv, e);
    chk({rdv[30:0], e}, 32'h1);
    apb(1'b1, 8'h18, 32'hffff_ffff, rdv, e);
    chk({31'h0, e}, 32'h1);
  endtask : t_unmapped

  task automatic t_ext_osc;
    logic [15:0] ctl [8] = '{16'h0006, 16'h0002, 16'h0042, 16'h00c2, 16'h00c2,
                             16'h0082, 16'h0082, 16'h0002};
    logic [2:0]  lv  [8] = '{3'b000, 3'b100, 3'b100, 3'b100, 3'b110,
                             3'b000, 3'b010, 3'b000};
    logic        ex  [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_EXT_OSC, {16'h0, ctl[i]});
      rd(ADDR_EXT_OSC, {16'h0, ctl[i]});
      standby <= lv[i][2];
      osc_request <= lv[i][1];
      settle();
      chk({31'h0, ext_osc_run}, {31'h0, ex[i]});
      chk({30'h0, crystal_select, osc_out_pin_gpio}, {30'h0, ctl[i][2], ~ctl[i][2]});
    end
    standby <= 1'b0;
    osc_request <= 1'b0;
  endtask : t_ext_osc

  task automatic t_sync;
    fll_fine_lock <= 1'b1;
    wr(ADDR_FLL, 32'h0000_001e);
    chk({31'h0, sync_in_progress}, 32'h1);
    wr(ADDR_PLL_RAT, 32'h0005_0123);
    chk({31'h0, wait_cnt > 0}, 32'h1);
    chk(wait_cnt, 32'h2);
    chk({31'h0, busy_at_ans}, 32'h1);
    rd(ADDR_FLL, 32'h0000_001e);
    wait_sync();
    chk({28'h0, fll_ctl}, 32'hf);
    chk({31'h0, fll_run}, 32'h1);
    chk({15'h0, pll_cfg.loop_ratio_int, pll_cfg.loop_ratio_frac, pll_cfg.frac_mode},
        {15'h0, 12'h123, 4'h5, 1'b1});
    chk({31'h0, fll_lock}, 32'h1);
    standby <= 1'b1;
    fll_clk_stopped <= 1'b1;
    fll_fine_lock <= 1'b0;
    settle();
    chk({31'h0, fll_lock}, 32'h1);
    standby <= 1'b0;
    settle();
    chk({31'h0, fll_lock}, 32'h0);
    fll_clk_stopped <= 1'b0;
    wr(ADDR_FLL, 32'h0);
    wait_sync();
    chk({27'h0, fll_ctl, fll_run}, 32'h0);
  endtask : t_sync

  task automatic t_pll;
    pll_lock <= 1'b1;
    wr(ADDR_PLL_RAT, 32'h0000_0123);
    wait_sync();
    chk({31'h0, pll_cfg.frac_mode}, 32'h0);
    for (int rs = 0; rs < 3; rs++) begin
      wr(ADDR_PLL_CTL, 32'h05a5_0002 | (rs << 4));
      wait_sync();
      chk({18'h0, pll_cfg.run, ref_sel_t'(pll_cfg.ref_sel), pll_cfg.ref_div},
          {18'h0, 1'b1, rs[1:0], 11'h5a5});
    end
    chk({31'h0, pll_cfg.pll_run}, 32'h1);
    wr(ADDR_PLL_CTL, 32'h0);
    wait_sync();
    chk({30'h0, pll_cfg.run, pll_cfg.pll_run}, 32'h0);
  endtask : t_pll

  task automatic t_fll_standby;
    standby <= 1'b1;
    fll_request <= 1'b1;
    wr(ADDR_FLL, 32'h0000_0082);
    wait_sync();
    settle();
    chk({31'h0, fll_run}, 32'h0);
    wr(ADDR_FLL, 32'h0000_00c2);
    wait_sync();
    settle();
    chk({31'h0, fll_run}, 32'h1);
    fll_request <= 1'b0;
    settle();
    chk({31'h0, fll_run}, 32'h0);
    standby <= 1'b0;
  endtask : t_fll_standby

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {standby, osc_request, fll_request, fll_clk_stopped, fll_fine_lock, pll_lock} = '0;
    error_cnt = 0;
    check_count = 0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_unmapped();
    t_ext_osc();
    t_sync();
    t_pll();
    t_fll_standby();
    close_out();
  end

  // The tests need well under 2000 cycles; a hang is cut at 20000
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
endmodule : tb_oscillator_pll_control
